// file: src/strap_cfg_pkg.sv
`default_nettype none
package strap_cfg_pkg;

  // Strap vector width and field positions
  localparam int unsigned STRAP_W        = 16;
  localparam int unsigned CLK_MULT_LSB   = 0;
  localparam int unsigned CLK_MULT_W     = 3;
  localparam int unsigned ENDIAN_BIT     = 3;
  localparam int unsigned SW_LOW_BIT     = 4;
  localparam int unsigned BOOT_WIDTH_LSB = 5;
  localparam int unsigned BOOT_WIDTH_W   = 2;
  localparam int unsigned RESET_MODE_BIT = 7;
  localparam int unsigned WDOG_DIS_BIT   = 8;
  localparam int unsigned PCI_MODE_LSB   = 9;
  localparam int unsigned PCI_MODE_W     = 3;
  localparam int unsigned SW_HIGH_LSB    = 12;
  localparam int unsigned SW_HIGH_W      = 4;

  // Field encodings
  localparam logic [2:0] CLK_MULT_X2       = 3'h0;
  localparam logic [1:0] BOOT_WIDTH_8      = 2'h0;
  localparam logic [1:0] BOOT_WIDTH_16     = 2'h1;
  localparam logic [1:0] BOOT_WIDTH_32     = 2'h2;
  localparam logic [1:0] BOOT_WIDTH_RSVD   = 2'h3;
  localparam logic       RESET_MODE_NORM   = 1'h0;
  localparam logic [2:0] PCI_DISABLED      = 3'h0;
  localparam logic [2:0] PCI_SAT_NOT_READY = 3'h1;
  localparam logic [2:0] PCI_SAT_SUSPEND   = 3'h2;
  localparam logic [2:0] PCI_HOST_EXT_ARB  = 3'h3;
  localparam logic [2:0] PCI_HOST_FIXED    = 3'h4;
  localparam logic [2:0] PCI_HOST_RR       = 3'h5;
  localparam logic [2:0] PCI_RSVD_6        = 3'h6;
  localparam logic [2:0] PCI_RSVD_7        = 3'h7;

  // Reset values of the held configuration before the first cold reset ends
  localparam logic [15:0] STRAP_RESET_VAL = 16'h0000;

  // System reset output stretch, in master clock cycles
  localparam int unsigned SYS_RESET_CYCLES = 4096;
  localparam int unsigned SYS_RESET_CNT_W  = 13;
  localparam logic [12:0] SYS_RESET_LAST   = 13'(SYS_RESET_CYCLES - 1);

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_COLD    = 3'b001,
    ST_STRETCH = 3'b010,
    ST_RUN     = 3'b100
  } seq_state_e;

endpackage : strap_cfg_pkg
`default_nettype wire

// file: src/boot_strap_vector_decoder.sv
// Operation
// - Sample straps during cold reset, use afterwards
// - Bits 2:0 pick PLL factor, 0 is x2
// - Bit 3: 0 little, 1 big endian
// - Bit 4 recorded for software only
// - Bits 15:12 recorded for software only
// - Bits 6:5 give boot device width
// - Bit 7 zero: system reset 4096 cycles
// - Bit 8 one disables the watchdog
// - Bits 11:9 select PCI interface mode
// - PCI enable resets to one for 1,2
// - Mode 2 holds CPU execution suspended
// - Modes 4,5 internal arbiter, fixed/round-robin
`timescale 1ns/1ps
`default_nettype none

module boot_strap_vector_decoder
  import strap_cfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        cold_reset_n,
  input  wire logic [15:0] memory_data_strap_pins,
  output logic             config_valid,
  output logic             system_reset_output_n,
  output logic [2:0]       cpu_clock_mult,
  output logic             cpu_clock_mult_reserved,
  output logic             big_endian,
  output logic [1:0]       boot_width,
  output logic             boot_width_reserved,
  output logic             reset_mode_reserved,
  output logic             watchdog_disable,
  output logic [2:0]       pci_mode,
  output logic             pci_mode_reserved,
  output logic             pci_enabled,
  output logic             pci_satellite,
  output logic             pci_host,
  output logic             pci_internal_arbiter,
  output logic             pci_round_robin,
  output logic             pci_enable_reset_value,
  output logic             cpu_suspend,
  output logic [15:0]      recorded_strap_field
);

  // Field slices of a strap vector; used for the reset value and at the latch
  function automatic logic [2:0] mult_field(input logic [15:0] vec);
    mult_field = vec[CLK_MULT_LSB +: CLK_MULT_W];
  endfunction : mult_field

  function automatic logic [1:0] width_field(input logic [15:0] vec);
    width_field = vec[BOOT_WIDTH_LSB +: BOOT_WIDTH_W];
  endfunction : width_field

  function automatic logic [2:0] mode_field(input logic [15:0] vec);
    mode_field = vec[PCI_MODE_LSB +: PCI_MODE_W];
  endfunction : mode_field

  // Reserved codes are passed on and flagged; the consumer decides what to do
  function automatic logic mult_is_reserved(input logic [15:0] vec);
    mult_is_reserved = (mult_field(vec) != CLK_MULT_X2);
  endfunction : mult_is_reserved

  function automatic logic width_is_reserved(input logic [15:0] vec);
    width_is_reserved = (width_field(vec) == BOOT_WIDTH_RSVD);
  endfunction : width_is_reserved

  function automatic logic reset_mode_is_reserved(input logic [15:0] vec);
    reset_mode_is_reserved = (vec[RESET_MODE_BIT] != RESET_MODE_NORM);
  endfunction : reset_mode_is_reserved

  // PCI mode decode, shared by the reset value and the latch
  function automatic logic pci_is_reserved(input logic [2:0] mode);
    pci_is_reserved = (mode == PCI_RSVD_6) || (mode == PCI_RSVD_7);
  endfunction : pci_is_reserved

  function automatic logic pci_en_init(input logic [2:0] mode);
    pci_en_init = (mode == PCI_SAT_NOT_READY) || (mode == PCI_SAT_SUSPEND);
  endfunction : pci_en_init

  function automatic logic pci_is_on(input logic [2:0] mode);
    pci_is_on = (mode != PCI_DISABLED) && !pci_is_reserved(mode);
  endfunction : pci_is_on

  function automatic logic pci_is_host(input logic [2:0] mode);
    pci_is_host = (mode == PCI_HOST_EXT_ARB) || (mode == PCI_HOST_FIXED)
                  || (mode == PCI_HOST_RR);
  endfunction : pci_is_host

  function automatic logic pci_is_internal(input logic [2:0] mode);
    pci_is_internal = (mode == PCI_HOST_FIXED) || (mode == PCI_HOST_RR);
  endfunction : pci_is_internal

  function automatic logic pci_is_rr(input logic [2:0] mode);
    pci_is_rr = (mode == PCI_HOST_RR);
  endfunction : pci_is_rr

  function automatic logic pci_is_suspend(input logic [2:0] mode);
    pci_is_suspend = (mode == PCI_SAT_SUSPEND);
  endfunction : pci_is_suspend

  seq_state_e                 state_q;
  seq_state_e                 state_d;
  logic [15:0]                sample_q;
  logic [15:0]                strap_q;
  logic [SYS_RESET_CNT_W-1:0] stretch_q;
  logic                       cold_release;
  logic                       stretch_done;
  logic [2:0]                 latch_mode;
  logic [2:0]                 mult_q;
  logic                       mult_rsvd_q;
  logic                       big_endian_q;
  logic [1:0]                 width_q;
  logic                       width_rsvd_q;
  logic                       reset_mode_rsvd_q;
  logic                       wdog_dis_q;
  logic [2:0]                 pci_mode_q;
  logic                       pci_rsvd_q;
  logic                       pci_on_q;
  logic                       pci_sat_q;
  logic                       pci_host_q;
  logic                       pci_int_arb_q;
  logic                       pci_rr_q;
  logic                       pci_en_init_q;
  logic                       cpu_suspend_q;

  assign cold_release = (state_q == ST_COLD) && cold_reset_n;
  assign stretch_done = (stretch_q == SYS_RESET_LAST);
  // Decode the sample about to be frozen, so flags land with the vector
  assign latch_mode   = mode_field(sample_q);

  // Track the pins every cycle of cold reset; the last sample wins
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      sample_q <= STRAP_RESET_VAL;
    else if (!cold_reset_n)
      sample_q <= memory_data_strap_pins;
  end

  // Freeze the vector at release so a glitch afterwards cannot reconfigure
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      strap_q <= STRAP_RESET_VAL;
    else if (cold_release)
      strap_q <= sample_q;
  end

  // Sequencer: cold reset, reset stretch, running
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_COLD:
        if (cold_reset_n)
          state_d = ST_STRETCH;
      ST_STRETCH:
        if (!cold_reset_n)
          state_d = ST_COLD;
        else if (stretch_done)
          state_d = ST_RUN;
      ST_RUN:
        if (!cold_reset_n)
          state_d = ST_COLD;
      default:
        state_d = ST_COLD;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      state_q <= ST_COLD;
    else
      state_q <= state_d;
  end

  // Stretch counter; the reserved reset mode still gets the normal length
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      stretch_q <= '0;
    else if (state_q == ST_STRETCH)
      stretch_q <= stretch_q + SYS_RESET_CNT_W'(1);
    else
      stretch_q <= '0;
  end

  // System reset stays low through cold reset and the stretch
  assign system_reset_output_n = (state_q == ST_RUN);
  assign config_valid          = (state_q != ST_COLD);

  // Clock multiplier; reserved codes are flagged, the PLL side decides
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      mult_q      <= mult_field(STRAP_RESET_VAL);
      mult_rsvd_q <= mult_is_reserved(STRAP_RESET_VAL);
    end
    else if (cold_release)
    begin
      mult_q      <= mult_field(sample_q);
      mult_rsvd_q <= mult_is_reserved(sample_q);
    end
  end

  // Byte order
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      big_endian_q <= STRAP_RESET_VAL[ENDIAN_BIT];
    else if (cold_release)
      big_endian_q <= sample_q[ENDIAN_BIT];
  end

  // Boot device width
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      width_q      <= width_field(STRAP_RESET_VAL);
      width_rsvd_q <= width_is_reserved(STRAP_RESET_VAL);
    end
    else if (cold_release)
    begin
      width_q      <= width_field(sample_q);
      width_rsvd_q <= width_is_reserved(sample_q);
    end
  end

  // Reset mode; the reserved setting only raises a flag, length is unchanged
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      reset_mode_rsvd_q <= reset_mode_is_reserved(STRAP_RESET_VAL);
    else if (cold_release)
      reset_mode_rsvd_q <= reset_mode_is_reserved(sample_q);
  end

  // Watchdog state after cold reset
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      wdog_dis_q <= STRAP_RESET_VAL[WDOG_DIS_BIT];
    else if (cold_release)
      wdog_dis_q <= sample_q[WDOG_DIS_BIT];
  end

  // PCI mode and its class flags
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pci_mode_q <= mode_field(STRAP_RESET_VAL);
      pci_rsvd_q <= pci_is_reserved(mode_field(STRAP_RESET_VAL));
      pci_on_q   <= pci_is_on(mode_field(STRAP_RESET_VAL));
      pci_sat_q  <= pci_en_init(mode_field(STRAP_RESET_VAL));
      pci_host_q <= pci_is_host(mode_field(STRAP_RESET_VAL));
    end
    else if (cold_release)
    begin
      pci_mode_q <= latch_mode;
      pci_rsvd_q <= pci_is_reserved(latch_mode);
      pci_on_q   <= pci_is_on(latch_mode);
      pci_sat_q  <= pci_en_init(latch_mode);
      pci_host_q <= pci_is_host(latch_mode);
    end
  end

  // Internal arbiter and its policy
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pci_int_arb_q <= pci_is_internal(mode_field(STRAP_RESET_VAL));
      pci_rr_q      <= pci_is_rr(mode_field(STRAP_RESET_VAL));
    end
    else if (cold_release)
    begin
      pci_int_arb_q <= pci_is_internal(latch_mode);
      pci_rr_q      <= pci_is_rr(latch_mode);
    end
  end

  // Reset value for the enable bit of the PCI control register
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      pci_en_init_q <= pci_en_init(mode_field(STRAP_RESET_VAL));
    else if (cold_release)
      pci_en_init_q <= pci_en_init(latch_mode);
  end

  // CPU held until the host side releases it elsewhere
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      cpu_suspend_q <= pci_is_suspend(mode_field(STRAP_RESET_VAL));
    else if (cold_release)
      cpu_suspend_q <= pci_is_suspend(latch_mode);
  end

  // Configuration outputs straight from the flops
  assign cpu_clock_mult          = mult_q;
  assign cpu_clock_mult_reserved = mult_rsvd_q;
  assign big_endian              = big_endian_q;
  assign boot_width              = width_q;
  assign boot_width_reserved     = width_rsvd_q;
  assign reset_mode_reserved     = reset_mode_rsvd_q;
  assign watchdog_disable        = wdog_dis_q;
  assign pci_mode                = pci_mode_q;
  assign pci_mode_reserved       = pci_rsvd_q;
  assign pci_enabled             = pci_on_q;
  assign pci_satellite           = pci_sat_q;
  assign pci_host                = pci_host_q;
  assign pci_internal_arbiter    = pci_int_arb_q;
  assign pci_round_robin         = pci_rr_q;
  assign pci_enable_reset_value  = pci_en_init_q;
  assign cpu_suspend             = cpu_suspend_q;

  // Whole vector kept for software, reserved bits included
  assign recorded_strap_field = strap_q;

endmodule : boot_strap_vector_decoder

`default_nettype wire

// file: bench/strap_source.sv
`timescale 1ns/1ps
`default_nettype none
// Board strap source; the bus is handed back to memory after cold reset
module strap_source
(
  input  wire logic        cold_reset_n,
  input  wire logic [15:0] board_vec,
  output logic      [15:0] pins
);
  // Steady pattern in cold reset, inverted after it so stale data shows
  assign pins = cold_reset_n ? ~board_vec : board_vec;
endmodule : strap_source
`default_nettype wire

// file: bench/boot_strap_vector_decoder_sva.sv
`timescale 1ns/1ps
`default_nettype none
module strap_chk
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        cold_reset_n,
  input wire logic [15:0] memory_data_strap_pins,
  input wire logic        config_valid,
  input wire logic        system_reset_output_n,
  input wire logic [2:0]  pci_mode,
  input wire logic        pci_enable_reset_value,
  input wire logic        cpu_suspend,
  input wire logic        pci_round_robin,
  input wire logic [15:0] recorded_strap_field
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [12:0] low_q;
  // Stretch length counter; cleared whenever the config is not live
  always_ff @(posedge core_clk)
  begin
    if (!resetn || !config_valid) low_q <= 13'h0;
    else if (!system_reset_output_n) low_q <= low_q + 13'h1;
  end
  property p_en; pci_enable_reset_value == (pci_mode inside {3'h1, 3'h2}); endproperty
  a_en: assert property (p_en) else $error("enable reset value wrong");
  property p_susp; cpu_suspend == (pci_mode == 3'h2); endproperty
  a_susp: assert property (p_susp) else $error("suspend wrong");
  property p_rr; pci_round_robin == (pci_mode == 3'h5); endproperty
  a_rr: assert property (p_rr) else $error("round robin wrong");
  property p_mode; pci_mode == recorded_strap_field[11:9]; endproperty
  a_mode: assert property (p_mode) else $error("pci mode wrong");
  property p_hold; config_valid && $past(config_valid) |-> $stable(recorded_strap_field); endproperty
  a_hold: assert property (p_hold) else $error("field moved");
  property p_latch; $rose(cold_reset_n) && $past(resetn) |=> config_valid &&
    recorded_strap_field == $past(memory_data_strap_pins, 2); endproperty
  a_latch: assert property (p_latch) else $error("latch wrong");
  property p_len; $rose(system_reset_output_n) |-> low_q == 13'h1000; endproperty
  a_len: assert property (p_len) else $error("reset length wrong");
  property p_cold; !cold_reset_n |=> !system_reset_output_n && !config_valid; endproperty
  a_cold: assert property (p_cold) else $error("cold reset not seen");
endmodule : strap_chk
`default_nettype wire

// file: bench/boot_strap_vector_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module boot_strap_vector_decoder_test;
  logic core_clk, resetn, cold_reset_n, config_valid, system_reset_output_n, big_endian;
  logic cpu_clock_mult_reserved, boot_width_reserved, reset_mode_reserved, watchdog_disable;
  logic pci_mode_reserved, pci_enabled, pci_satellite, pci_host, pci_internal_arbiter;
  logic pci_round_robin, pci_enable_reset_value, cpu_suspend;
  logic [2:0] cpu_clock_mult, pci_mode;
  logic [1:0] boot_width;
  logic [15:0] board_vec, memory_data_strap_pins, recorded_strap_field;
  int n_fail, comparisons, n;
  // Vector, {en, suspend, rr, int arb, host, big, wdog off, width rsvd},
  // then {pci rsvd, pci on, satellite, rst mode rsvd, mult rsvd, valid, sys reset, 0}
  logic [31:0] rows [8] = '{32'h01080604, 32'hf2108064, 32'h0460c164, 32'h06200844,
                            32'h08401844, 32'h5a003844, 32'h0c800094, 32'h0e0b048c};
  boot_strap_vector_decoder dut (.*);
  strap_source board (.cold_reset_n, .board_vec, .pins(memory_data_strap_pins));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    if (got !== exp) n_fail++;
  endtask : chk
  // Short cold reset; leaves two cycles after release, stretch still running
  task automatic cold_boot(input logic [15:0] v);
    cold_reset_n = 1'b0;
    board_vec = v;
    repeat (2) @(negedge core_clk);
    cold_reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask : cold_boot
  task automatic give_verdict();
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    resetn = 1'b0;
    cold_reset_n = 1'b0;
    board_vec = 16'h0;
    repeat (20) @(negedge core_clk);
    chk("config_valid", 16'h0, {15'h0, config_valid});
    resetn = 1'b1;
    // Each new cold reset aborts the previous stretch
    foreach (rows[i])
    begin
      cold_boot(rows[i][31:16]);
      chk("field", rows[i][31:16], recorded_strap_field);
      chk("flags", {8'h00, rows[i][15:8]}, {8'h00, pci_enable_reset_value, cpu_suspend,
        pci_round_robin, pci_internal_arbiter, pci_host, big_endian, watchdog_disable,
        boot_width_reserved});
      chk("flags2", {8'h00, rows[i][7:0]}, {8'h00, pci_mode_reserved, pci_enabled,
        pci_satellite, reset_mode_reserved, cpu_clock_mult_reserved, config_valid,
        system_reset_output_n, 1'b0});
      chk("fields", {8'h00, rows[i][27:25], rows[i][22:21], rows[i][18:16]},
        {8'h00, pci_mode, boot_width, cpu_clock_mult});
    end
    cold_boot(16'h9048);
    n = 2;
    while (!system_reset_output_n && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("stretch", 16'd4097, n[15:0]);
    chk("held", 16'h9048, recorded_strap_field);
    // Block reset mid-run clears everything; a fresh cold reset reloads
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("cleared", 16'h0, recorded_strap_field);
    chk("cleared state", 16'h0,
      {13'h0, config_valid, system_reset_output_n, big_endian});
    resetn = 1'b1;
    cold_boot(16'h0460);
    chk("reloaded", 16'h0460, recorded_strap_field);
    chk("suspend", 16'h0003, {14'h0, cpu_suspend, pci_satellite});
    give_verdict();
  end
  initial
  begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule : boot_strap_vector_decoder_test
bind boot_strap_vector_decoder strap_chk chk_i (.*);
`default_nettype wire
